// ===== design/layer_blend_transparency.sv
// Notes on behaviour
// [R01] blend ratio is the 8-bit field bits 7:0, meaning value/256
// [R02] layers 0-4: bit 13 picks programmed ratio or layer-five pixel as ratio
// [R03] bit 14 adds 1/256 to a nonzero effective ratio
// [R04] bit 15 swaps which image is weighted by ratio and by one minus ratio
// [R05] bit 16 overlays the layer by blending, else by transparent colour key
// [R06] alpha flag: direct pixel msb, or msb of the palette entry
// [R07] software sets blend enable and pixel alpha before expecting a blend
// [R08] layer five blend register: no plane select, unused bits read zero
// [R09] 15-bit transparent code in bits 14:0; matching pixels are transparent
// [R10] 8-bit indexed pixels compare only key bits 7:0
// [R11] zero bit 15: 0 makes code zero transparent, 1 keeps it opaque
// [R12] key zero with zero bit zero makes colour zero transparent
// [R13] layer zero key still applies while that layer is blending
// [R14] palette alpha zero: no blend, overlay by key; alpha one: blend
// [R15] components mixed in fixed point and truncated to 8 bits
`timescale 1ns/1ns
module layer_blend_transparency
  import blend_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // register port
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [DATA_W-1:0]  reg_rdata,
  // pixel of the layer being composed and the stack below it
  input  wire logic               pix_valid,
  input  wire logic [2:0]         pix_layer,
  input  wire logic [CODE_W-1:0]  pix_code,
  input  wire logic               pix_indirect,
  input  wire logic               pal_alpha,
  input  wire logic [RGB_W-1:0]   up_rgb,
  input  wire logic [RGB_W-1:0]   low_rgb,
  input  wire logic [COMP_W-1:0]  plane_ratio,
  // composed pixel
  output logic                    out_valid,
  output logic      [RGB_W-1:0]   out_rgb,
  output logic                    out_blended
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [BLEND_W-1:0] blend_ctl      [LAYERS];
  logic [BLEND_W-1:0] next_blend_ctl [LAYERS];
  logic [KEY_W-1:0]   key_reg        [KEYS];
  logic [KEY_W-1:0]   next_key_reg   [KEYS];
  logic [DATA_W-1:0]  next_rdata;

  // pixel path state
  logic               next_out_valid;
  logic [RGB_W-1:0]   next_out_rgb;
  logic               next_out_blended;

  // per-pixel decode
  logic               layer_ok;
  logic [BLEND_W-1:0] ctl;
  logic               alpha_flag;
  logic               blend_on;
  logic               has_key;
  logic [KEY_W-1:0]   sel_key;
  logic [COMP_W-1:0]  src_ratio;
  logic [RATIO_W-1:0] eff_ratio;
  logic [RGB_W-1:0]   mix_rgb;
  logic               keyed;

  ////////////////////////////////////////////////////////////////////////////
  // register writes and reads; reads answer one cycle later, zero elsewhere
  always_comb begin
    next_blend_ctl = blend_ctl;
    next_key_reg   = key_reg;
    next_rdata     = '0;
    if (reg_wr) begin
      for (int i = 0; i < LAYERS; i++) begin
        if (reg_addr == BLEND_OFS[i]) begin
          // layer five has no plane select, so its bit 13 never stores
          next_blend_ctl[i] = reg_wdata[BLEND_W-1:0] & ((i == LAYERS - 1) ? BLEND5_MASK : BLEND_MASK); // [R08]
        end
      end
      for (int k = 0; k < KEYS; k++) begin
        if (reg_addr == KEY_OFS[k]) begin
          next_key_reg[k] = reg_wdata[KEY_W-1:0]; // [R09]
        end
      end
    end
    if (reg_rd) begin
      for (int i = 0; i < LAYERS; i++) begin
        if (reg_addr == BLEND_OFS[i]) begin
          next_rdata = {15'h0000, blend_ctl[i]}; // [R08]
        end
      end
      for (int k = 0; k < KEYS; k++) begin
        if (reg_addr == KEY_OFS[k]) begin
          next_rdata = {16'h0000, key_reg[k]};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LAYERS; i++) begin
        blend_ctl[i] <= BLEND_RST; // [R08]
      end
      for (int k = 0; k < KEYS; k++) begin
        key_reg[k] <= KEY_RST;
      end
      reg_rdata <= '0;
    end else begin
      blend_ctl <= next_blend_ctl;
      key_reg   <= next_key_reg;
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // layer parameters for the pixel in flight
  always_comb begin
    layer_ok = pix_layer < LAYER_COUNT;
    ctl      = layer_ok ? blend_ctl[pix_layer] : BLEND_RST;
    has_key  = 1'b0;
    sel_key  = KEY_RST;
    for (int k = 0; k < KEYS; k++) begin
      if (pix_layer == KEY_LAYER[k]) begin
        has_key = 1'b1;
        sel_key = key_reg[k];
      end
    end
  end

  // alpha comes from the palette for indexed pixels, else from the pixel msb
  assign alpha_flag = pix_indirect ? pal_alpha : pix_code[ALPHA_BIT]; // [R06] [R14]
  // both enable and alpha are needed; either alone leaves the layer keyed
  assign blend_on   = ctl[EN_BIT] & alpha_flag; // [R05] [R07]

  // ratio source: layer five never reads itself as a plane
  assign src_ratio = (ctl[SRC_BIT] && pix_layer != PLANE_LAYER) ? plane_ratio
                                                                : ctl[RATIO_MSB:0]; // [R01] [R02]
  // the bump lets a full 255 reach exactly 256/256, showing the upper image when bit 15 is clear
  assign eff_ratio = {1'b0, src_ratio} + {8'h00, ctl[BUMP_BIT] & (src_ratio != 8'h00)}; // [R03]

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic and key compare
  blend_mixer u_mixer (
    .upper_rgb (up_rgb),
    .lower_rgb (low_rgb),
    .ratio     (eff_ratio),
    .swap      (ctl[SEL_BIT]), // [R04]
    .mix_rgb   (mix_rgb)
  );

  transparency_keyer u_keyer (
    .code     (pix_code),
    .indirect (pix_indirect),
    .key      (sel_key),
    .has_key  (has_key),
    .keyed    (keyed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // overlay decision; one register stage, last colour held while idle
  always_comb begin
    next_out_valid   = pix_valid;
    next_out_rgb     = out_rgb;
    next_out_blended = 1'b0;
    if (pix_valid) begin
      if (!layer_ok) begin
        next_out_rgb = low_rgb;
      end else if (blend_on) begin
        // only layer zero keeps its key while blending
        if (pix_layer == KEY_IN_MIX && keyed) begin
          next_out_rgb = low_rgb; // [R13]
        end else begin
          next_out_rgb     = mix_rgb; // [R05] [R15]
          next_out_blended = 1'b1;
        end
      end else if (keyed) begin
        next_out_rgb = low_rgb; // [R09] [R14]
      end else begin
        next_out_rgb = up_rgb; // [R11]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid   <= 1'b0;
      out_rgb     <= '0;
      out_blended <= 1'b0;
    end else begin
      out_valid   <= next_out_valid;
      out_rgb     <= next_out_rgb;
      out_blended <= next_out_blended;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the pixel path and the layer five register read
  AST_KEYED_SHOWS_LOWER: assert property ( // [R09]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && layer_ok && !blend_on && keyed) |=> (out_rgb == $past(low_rgb) && !out_blended))
    else $error("keyed pixel did not show the lower image");

  AST_OPAQUE_SHOWS_UPPER: assert property ( // [R05]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && layer_ok && !blend_on && !keyed) |=> (out_rgb == $past(up_rgb)))
    else $error("opaque pixel did not show the upper image");

  AST_RATIO_ZERO_LOWER: assert property ( // [R01]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && layer_ok && blend_on && !keyed && !ctl[SEL_BIT] && !ctl[SRC_BIT]
     && ctl[RATIO_MSB:0] == 8'h00) |=> (out_rgb == $past(low_rgb) && out_blended))
    else $error("zero ratio did not give the lower image");

  AST_BUMP_FULL_UPPER: assert property ( // [R03]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && layer_ok && blend_on && !keyed && !ctl[SEL_BIT] && ctl[BUMP_BIT]
     && src_ratio == 8'hFF) |=> (out_rgb == $past(up_rgb)))
    else $error("bumped full ratio did not give the upper image");

  AST_SWAP_ZERO_UPPER: assert property ( // [R04]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && layer_ok && blend_on && !keyed && ctl[SEL_BIT] && src_ratio == 8'h00)
    |=> (out_rgb == $past(up_rgb)))
    else $error("swapped equation with zero ratio did not give the upper image");

  AST_PLANE_RATIO_USED: assert property ( // [R02]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && pix_layer < PLANE_LAYER && blend_on && !keyed && ctl[SRC_BIT]
     && !ctl[SEL_BIT] && plane_ratio == 8'h00 && ctl[RATIO_MSB:0] != 8'h00)
    |=> (out_rgb == $past(low_rgb)))
    else $error("plane pixel was not used as the ratio");

  AST_NO_ALPHA_NO_BLEND: assert property ( // [R06]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && ctl[EN_BIT] && !alpha_flag) |=> !out_blended)
    else $error("pixel without alpha was blended");

  AST_L0_KEY_IN_BLEND: assert property ( // [R13]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && pix_layer == KEY_IN_MIX && blend_on && keyed)
    |=> (out_rgb == $past(low_rgb) && !out_blended))
    else $error("layer zero key ignored while blending");

  AST_ZERO_CODE_OPAQUE: assert property ( // [R11]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && has_key && !blend_on && sel_key[ZT_BIT] && !pix_indirect
     && pix_code[KEY_MSB:0] == 15'h0000) |=> (out_rgb == $past(up_rgb)))
    else $error("code zero was keyed although marked opaque");

  AST_L5_READ_CLEAN: assert property ( // [R08]
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == BLEND_OFS[LAYERS-1]) |=> (reg_rdata[31:17] == 15'h0000
     && reg_rdata[SRC_BIT:8] == 6'h00))
    else $error("layer five blend read shows unused bits");

  ////////////////////////////////////////////////////////////////////////////
  // checks on keying, ratio edges, blend enable and alpha, and the register side
  AST_BLEND_NEEDS_ENABLE: assert property ( // [R05]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && !ctl[EN_BIT]) |=> !out_blended)
    else $error("layer without blend enable was blended");

  AST_INDEXED_KEY_LOW_BYTE: assert property ( // [R10]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && has_key && !blend_on && pix_indirect && pix_code[IDX_MSB:0] != 8'h00
     && pix_code[IDX_MSB:0] == sel_key[IDX_MSB:0]) |=> (out_rgb == $past(low_rgb) && !out_blended))
    else $error("indexed pixel matching the key low byte was shown");

  AST_ZERO_KEY_ZERO_CODE: assert property ( // [R12]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && has_key && !blend_on && sel_key == 16'h0000 && !pix_indirect
     && pix_code[KEY_MSB:0] == 15'h0000) |=> (out_rgb == $past(low_rgb)))
    else $error("colour zero with a zero key was not transparent");

  // a zero ratio must stay zero even with the bump set
  AST_BUMP_ZERO_STAYS: assert property ( // [R03]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && layer_ok && blend_on && !keyed && !ctl[SEL_BIT] && ctl[BUMP_BIT]
     && src_ratio == 8'h00) |=> (out_rgb == $past(low_rgb) && out_blended))
    else $error("bump was applied to a zero ratio");

  AST_PALETTE_ALPHA_BLENDS: assert property ( // [R14]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && layer_ok && pix_indirect && pal_alpha && ctl[EN_BIT]
     && !(pix_layer == KEY_IN_MIX && keyed)) |=> out_blended)
    else $error("indexed pixel with palette alpha was not blended");

  AST_OTHER_KEY_IGNORED_IN_BLEND: assert property ( // [R13]
    @(posedge sys_clk) disable iff (!rst_n)
    (pix_valid && layer_ok && pix_layer != KEY_IN_MIX && blend_on) |=> out_blended)
    else $error("layer other than zero was keyed while blending");

  // bit 13 and the reserved bits of layer five must never hold a one
  AST_L5_UNUSED_CLEAR: assert property ( // [R08]
    @(posedge sys_clk) disable iff (!rst_n)
    (blend_ctl[LAYERS-1] & ~BLEND5_MASK) == 17'h00000)
    else $error("layer five blend register stored an unused bit");

  // read data stand for one cycle only, so a stale word never looks fresh
  AST_RDATA_IDLE_ZERO: assert property ( // [R08]
    @(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> (reg_rdata == 32'h00000000))
    else $error("read data shown without a read strobe");

endmodule

// ===== design/blend_pkg.sv
package blend_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register port and geometry
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int LAYERS  = 6;
  localparam int KEYS    = 3;
  localparam int COMP_W  = 8;
  localparam int RGB_W   = 24;
  localparam int CODE_W  = 16;
  localparam int BLEND_W = 17;
  localparam int KEY_W   = 16;
  localparam int RATIO_W = 9;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (plain port, printed offsets used as addresses)
  localparam logic [ADDR_W-1:0] BLEND_OFS [LAYERS] = '{12'h0B4, 12'h188, 12'h18C,
                                                        12'h190, 12'h194, 12'h198};
  localparam logic [ADDR_W-1:0] KEY_OFS   [KEYS]   = '{12'h0BC, 12'h0C0, 12'h0C2};
  // layer served by each transparency key register, same order as KEY_OFS
  localparam logic [2:0]        KEY_LAYER [KEYS]   = '{3'h0, 3'h3, 3'h2};

  ////////////////////////////////////////////////////////////////////////////
  // blend control fields
  localparam int RATIO_MSB = 7;
  localparam int SRC_BIT   = 13;
  localparam int BUMP_BIT  = 14;
  localparam int SEL_BIT   = 15;
  localparam int EN_BIT    = 16;
  localparam logic [BLEND_W-1:0] BLEND_MASK  = 17'h1E0FF;
  localparam logic [BLEND_W-1:0] BLEND5_MASK = 17'h1C0FF;
  localparam logic [BLEND_W-1:0] BLEND_RST   = 17'h00000;

  ////////////////////////////////////////////////////////////////////////////
  // transparency key fields and pixel fields
  localparam int KEY_MSB   = 14;
  localparam int ZT_BIT    = 15;
  localparam int IDX_MSB   = 7;
  localparam int ALPHA_BIT = 15;
  localparam logic [KEY_W-1:0] KEY_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // ratio arithmetic and layer codes
  localparam logic [RATIO_W-1:0] RATIO_ONE   = 9'h100;
  localparam logic [2:0]         LAYER_COUNT = 3'h6;
  localparam logic [2:0]         PLANE_LAYER = 3'h5;
  localparam logic [2:0]         KEY_IN_MIX  = 3'h0;

endpackage

// ===== design/blend_mixer.sv
`timescale 1ns/1ns
module blend_mixer
  import blend_pkg::*;
(
  // colours in
  input  wire logic [RGB_W-1:0]   upper_rgb,
  input  wire logic [RGB_W-1:0]   lower_rgb,
  // ratio in 1/256 units, 0..256
  input  wire logic [RATIO_W-1:0] ratio,
  input  wire logic               swap,
  // mixed colour
  output logic      [RGB_W-1:0]   mix_rgb
);

  logic [RATIO_W-1:0] r_up;
  logic [RATIO_W-1:0] r_lo;

  // equation select picks which image takes the ratio
  assign r_up = swap ? RATIO_ONE - ratio : ratio;
  assign r_lo = RATIO_ONE - r_up;

  ////////////////////////////////////////////////////////////////////////////
  // one weighted sum per component; the sum never exceeds 255*256
  genvar c;
  generate
    for (c = 0; c < RGB_W / COMP_W; c++) begin : g_comp
      logic [COMP_W+RATIO_W-1:0] p_up;
      logic [COMP_W+RATIO_W-1:0] p_lo;
      logic [COMP_W+RATIO_W-1:0] sum;
      assign p_up = upper_rgb[c*COMP_W +: COMP_W] * r_up;
      assign p_lo = lower_rgb[c*COMP_W +: COMP_W] * r_lo;
      assign sum  = p_up + p_lo;
      // truncation, not rounding: cheaper and matches the ratio/256 scale
      assign mix_rgb[c*COMP_W +: COMP_W] = sum[COMP_W +: COMP_W]; // [R15]
    end
  endgenerate

endmodule

// ===== design/transparency_keyer.sv
`timescale 1ns/1ns
module transparency_keyer
  import blend_pkg::*;
(
  // pixel
  input  wire logic [CODE_W-1:0] code,
  input  wire logic              indirect,
  // key register of the layer
  input  wire logic [KEY_W-1:0]  key,
  input  wire logic              has_key,
  // result
  output logic                   keyed
);

  logic match;
  logic zero;

  // 8-bit indexed pixels only compare the low byte of the key
  assign match = indirect ? (code[IDX_MSB:0] == key[IDX_MSB:0])  // [R10]
                          : (code[KEY_MSB:0] == key[KEY_MSB:0]); // [R09]
  assign zero  = indirect ? (code[IDX_MSB:0] == '0) : (code[KEY_MSB:0] == '0);

  // code zero follows the zero bit alone, even when the key is also zero
  assign keyed = has_key & (zero ? ~key[ZT_BIT] : match); // [R11] [R12]

endmodule

// ===== verif/tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end
module tb;
  import blend_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic              sys_clk;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              pix_valid;
  logic [2:0]        pix_layer;
  logic [CODE_W-1:0] pix_code;
  logic              pix_indirect;
  logic              pal_alpha;
  logic [RGB_W-1:0]  up_rgb;
  logic [RGB_W-1:0]  low_rgb;
  logic [COMP_W-1:0] plane_ratio;
  logic              out_valid;
  logic [RGB_W-1:0]  out_rgb;
  logic              out_blended;
  int                n_fail;
  int                samples_checked;
  // distinct lane values so a swapped or shifted lane shows up
  localparam logic [RGB_W-1:0] UP = 24'hFF8040;
  localparam logic [RGB_W-1:0] LO = 24'h10C0F0;
  localparam logic [7:0] RATIOS [3] = '{8'h00, 8'h40, 8'hFF};

  layer_blend_transparency i_layer_blend_transparency (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .pix_valid    (pix_valid),
    .pix_layer    (pix_layer),
    .pix_code     (pix_code),
    .pix_indirect (pix_indirect),
    .pal_alpha    (pal_alpha),
    .up_rgb       (up_rgb),
    .low_rgb      (low_rgb),
    .plane_ratio  (plane_ratio),
    .out_valid    (out_valid),
    .out_rgb      (out_rgb),
    .out_blended  (out_blended)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // reference mix, worked out independently per 8-bit lane, truncated
  function automatic logic [RGB_W-1:0] mixf(input logic [RGB_W-1:0] u, input logic [RGB_W-1:0] l,
                                            input logic [RATIO_W-1:0] r, input logic sel);
    logic [RGB_W-1:0]   o;
    logic [RATIO_W-1:0] wu;
    logic [RATIO_W-1:0] wl;
    wu = sel ? RATIO_ONE - r : r;
    wl = RATIO_ONE - wu;
    for (int j = 0; j < 3; j++) begin
      o[j*8 +: 8] = 8'((18'(u[j*8 +: 8]) * wu + 18'(l[j*8 +: 8]) * wl) >> 8);
    end
    return o;
  endfunction

  // register write: one cycle strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // register read: data only in the cycle after the strobe, zero after that
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge sys_clk);
    #1;
    `CHK(reg_rdata, 32'h00000000)
  endtask

  // one pixel in, composed pixel checked one cycle later
  task automatic pix_chk(input logic [2:0] ly, input logic [CODE_W-1:0] c, input logic ind, input logic al,
                         input logic [COMP_W-1:0] pr, input logic [RGB_W-1:0] er, input logic eb);
    @(posedge sys_clk);
    pix_valid    <= 1'b1;
    pix_layer    <= ly;
    pix_code     <= c;
    pix_indirect <= ind;
    pal_alpha    <= al;
    up_rgb       <= UP;
    low_rgb      <= LO;
    plane_ratio  <= pr;
    @(posedge sys_clk);
    pix_valid    <= 1'b0;
    #1;
    `CHK(out_valid, 1'b1)
    `CHK(out_rgb, er)
    `CHK(out_blended, eb)
    // valid drops after one cycle while the colour holds
    @(posedge sys_clk);
    #1;
    `CHK(out_valid, 1'b0)
    `CHK(out_rgb, er)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    #500000;
    n_fail++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [8:0] r;
    n_fail = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {pix_valid, pix_layer, pix_code, pix_indirect, pal_alpha} = '0;
    {up_rgb, low_rgb, plane_ratio} = '0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, writable bits, reserved bits and an unmapped place
    for (int i = 0; i < LAYERS; i++) begin
      rd_chk(BLEND_OFS[i], 32'h00000000);
      wr(BLEND_OFS[i], 32'hFFFFFFFF);
      rd_chk(BLEND_OFS[i], {15'h0000, (i == LAYERS - 1) ? BLEND5_MASK : BLEND_MASK});
      wr(BLEND_OFS[i], 32'h00000000);
    end
    for (int i = 0; i < KEYS; i++) begin
      rd_chk(KEY_OFS[i], 32'h00000000);
      wr(KEY_OFS[i], 32'hFFFFFFFF);
      rd_chk(KEY_OFS[i], 32'h0000FFFF);
      wr(KEY_OFS[i], 32'h00000000);
    end
    wr(12'h100, 32'hFFFFFFFF);
    rd_chk(12'h100, 32'h00000000);
    $display("test registers done");
    // every ratio edge, bump and equation on layer 3
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 2; s++) begin
        for (int b = 0; b < 2; b++) begin
          wr(BLEND_OFS[3], {15'h0000, 1'b1, 1'(s), 1'(b), 1'b0, 5'h00, RATIOS[k]});
          r = {1'b0, RATIOS[k]} + ((b == 1 && RATIOS[k] != 8'h00) ? 9'h001 : 9'h000);
          pix_chk(3'h3, 16'h8123, 1'b0, 1'b0, 8'h00, mixf(UP, LO, r, 1'(s)), 1'b1);
        end
      end
    end
    $display("test mix done");
    // plane source on layers 0-4, ignored on layer 5
    for (int i = 0; i < 5; i++) begin
      wr(BLEND_OFS[i], 32'h00012010);
      pix_chk(3'(i), 16'h8123, 1'b0, 1'b0, 8'hC0, mixf(UP, LO, 9'h0C0, 1'b0), 1'b1);
    end
    wr(BLEND_OFS[5], 32'h00012010);
    pix_chk(3'h5, 16'h8123, 1'b0, 1'b0, 8'hC0, mixf(UP, LO, 9'h010, 1'b0), 1'b1);
    // bump on a plane ratio: zero stays zero, full reaches the upper image
    wr(BLEND_OFS[1], 32'h00016010);
    pix_chk(3'h1, 16'h8123, 1'b0, 1'b0, 8'h00, LO, 1'b1);
    pix_chk(3'h1, 16'h8123, 1'b0, 1'b0, 8'hFF, UP, 1'b1);
    $display("test plane done");
    // alpha source: pixel msb for direct, palette msb for indexed
    pix_chk(3'h4, 16'h0123, 1'b0, 1'b1, 8'hC0, UP, 1'b0);
    pix_chk(3'h4, 16'h8023, 1'b1, 1'b0, 8'hC0, UP, 1'b0);
    pix_chk(3'h4, 16'h0023, 1'b1, 1'b1, 8'hC0, mixf(UP, LO, 9'h0C0, 1'b0), 1'b1);
    $display("test alpha done");
    // keying on layer 2 with blending off
    wr(BLEND_OFS[2], 32'h00000000);
    wr(KEY_OFS[2], 32'h00001234);
    pix_chk(3'h2, 16'h1234, 1'b0, 1'b0, 8'h00, LO, 1'b0);
    pix_chk(3'h2, 16'h9234, 1'b0, 1'b0, 8'h00, LO, 1'b0);
    pix_chk(3'h2, 16'h1235, 1'b0, 1'b0, 8'h00, UP, 1'b0);
    pix_chk(3'h2, 16'h0000, 1'b0, 1'b0, 8'h00, LO, 1'b0);
    wr(KEY_OFS[2], 32'h00000000);
    pix_chk(3'h2, 16'h0000, 1'b0, 1'b0, 8'h00, LO, 1'b0);
    pix_chk(3'h2, 16'h0001, 1'b0, 1'b0, 8'h00, UP, 1'b0);
    wr(KEY_OFS[2], 32'h00008000);
    pix_chk(3'h2, 16'h0000, 1'b0, 1'b0, 8'h00, UP, 1'b0);
    wr(KEY_OFS[2], 32'h00007F55);
    pix_chk(3'h2, 16'h0055, 1'b1, 1'b0, 8'h00, LO, 1'b0);
    pix_chk(3'h2, 16'h0055, 1'b0, 1'b0, 8'h00, UP, 1'b0);
    $display("test keying done");
    // layer 0 key holds while blending, layer 3 key does not
    wr(KEY_OFS[0], 32'h00000321);
    wr(BLEND_OFS[0], 32'h00010080);
    pix_chk(3'h0, 16'h8321, 1'b0, 1'b0, 8'h00, LO, 1'b0);
    wr(KEY_OFS[1], 32'h00000321);
    wr(BLEND_OFS[3], 32'h00010080);
    pix_chk(3'h3, 16'h8321, 1'b0, 1'b0, 8'h00, mixf(UP, LO, 9'h080, 1'b0), 1'b1);
    wr(BLEND_OFS[3], 32'h00000000);
    pix_chk(3'h3, 16'h8321, 1'b0, 1'b0, 8'h00, LO, 1'b0);
    pix_chk(3'h6, 16'h8123, 1'b0, 1'b0, 8'h00, LO, 1'b0);
    $display("test layer zero key done");
    // reset in mid-run clears out_valid, out_rgb, the layer 3 blend register and key register 0
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK(out_valid, 1'b0)
    `CHK(out_rgb, 24'h000000)
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(BLEND_OFS[3], 32'h00000000);
    rd_chk(KEY_OFS[0], 32'h00000000);
    pix_chk(3'h0, 16'h8321, 1'b0, 1'b0, 8'h00, UP, 1'b0);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
